// *** verilog/sncfg_pkg.sv ***
package sncfg_pkg;
    // -----------------------------------------------------------
    // Register numbers on the configuration port
    // -----------------------------------------------------------
    localparam logic [7:0] REG_IDENT = 8'h00;
    localparam logic [7:0] REG_DESC = 8'h01;
    localparam logic [7:0] REG_SWCFG = 8'h04;
    localparam logic [7:0] REG_NODE = 8'h05;
    localparam logic [7:0] REG_PLL = 8'h06;
    localparam logic [7:0] REG_SWDIV = 8'h07;
    localparam logic [7:0] REG_REFDIV = 8'h08;
    localparam logic [7:0] REG_DIRLO = 8'h0c;
    localparam logic [7:0] REG_DIRHI = 8'h0d;
    // -----------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------
    localparam int LOCK_ALL_BIT = 31;
    localparam int LOCK_PLL_BIT = 8;
    localparam int HDR_BIT = 0;
    localparam int OD_LSB = 23;
    localparam int OD_MSB = 25;
    localparam int FB_LSB = 8;
    localparam int FB_MSB = 20;
    localparam int IN_LSB = 0;
    localparam int IN_MSB = 6;
    localparam int DIV_W = 16;
    localparam int NODE_W = 16;
    // -----------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------
    localparam logic [15:0] NODE_RST = 16'h0000;
    localparam logic [15:0] SWDIV_RST = 16'h0000;
    localparam logic [15:0] REFDIV_RST = 16'h0003;
    localparam logic [31:0] DIR_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // PLL reset words per strap code {pin_b, pin_a}
    localparam logic [31:0] PLL_RST_S0 = 32'h0080_0c00;
    localparam logic [31:0] PLL_RST_S1 = 32'h0080_1800;
    localparam logic [31:0] PLL_RST_S2 = 32'h0100_0c00;
    localparam logic [31:0] PLL_RST_S3 = 32'h0100_1800;
    // -----------------------------------------------------------
    // Strap capture states
    // -----------------------------------------------------------
    typedef enum logic [0:0] {
        CAP_WAIT = 1'b0,
        CAP_DONE = 1'b1
    } cap_state_e;
endpackage : sncfg_pkg

// *** verilog/switch_node_config_regs.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Ident: chip code, straps, revision, version
// - Description: links, cores, links per core
// - Lock bit 31 rejects all writes
// - Lock bit 8 blocks PLL updates
// - Bit 0 selects single-byte headers
// - Writable 16-bit node number, resets zero
// - Destination compared from most significant bit
// - PLL register write resets the tile
// - PLL fields, reset values from straps
// - Switch tick every divider plus one
// - Reference tick every divider plus one
// - Route by most significant mismatching bit
// - Low table: bits 7..0 directions
// - High table: bits 15..8 directions
module switch_node_config_regs #(
    parameter logic [7:0] CHIP_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01,
    parameter logic [7:0] VERSION = 8'h01,
    parameter logic [7:0] LINK_COUNT = 8'h08,
    parameter logic [7:0] CORE_COUNT = 8'h01,
    parameter logic [7:0] LINKS_PER_CORE = 8'h04
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic boot_strap_pin_a,
    input wire logic boot_strap_pin_b,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic cfg_rejected,
    output logic [31:0] cfg_rdata,
    input wire logic route_req,
    input wire logic [15:0] route_dest,
    output logic route_valid,
    output logic route_local,
    output logic [3:0] route_dir,
    output logic header_single_byte,
    output logic [15:0] node_id,
    output logic [2:0] pll_output_divider,
    output logic [12:0] pll_feedback_mult,
    output logic [6:0] pll_input_div,
    output logic tile_reset,
    output logic switch_clk_tick,
    output logic ref_clk_tick
);
    // -----------------------------------------------------------
    // State
    // -----------------------------------------------------------
    sncfg_pkg::cap_state_e cap_reg; // Strap capture phase
    logic [1:0] strap_reg; // {pin_b, pin_a} at boot
    logic lock_all_reg; // Global write lock
    logic lock_pll_reg; // PLL write lock
    logic hdr_reg; // Header mode
    logic [15:0] node_reg; // Node number
    logic [2:0] od_reg; // PLL output divider
    logic [12:0] fb_reg; // PLL feedback ratio
    logic [6:0] in_reg; // PLL input divider
    logic [15:0] swdiv_reg; // Switch clock divider
    logic [15:0] refdiv_reg; // Reference divider
    logic [31:0] dirlo_reg; // Directions 7..0
    logic [31:0] dirhi_reg; // Directions 15..8
    logic [1:0] tick_reg; // Derived clock ticks
    // -----------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------
    // Index of highest set bit; zero when none
    function automatic logic [3:0] top_bit(input logic [15:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : top_bit
    // PLL reset word selected by strap code
    function automatic logic [31:0] pll_rst(input logic [1:0] s);
        logic [31:0] w;
        case (s)
            2'h0: w = sncfg_pkg::PLL_RST_S0;
            2'h1: w = sncfg_pkg::PLL_RST_S1;
            2'h2: w = sncfg_pkg::PLL_RST_S2;
            default: w = sncfg_pkg::PLL_RST_S3;
        endcase
        return w;
    endfunction : pll_rst
    // -----------------------------------------------------------
    // Request decode
    // -----------------------------------------------------------
    // Requests are refused during the one capture cycle
    wire taken = clk_en && cfg_req && (cap_reg == sncfg_pkg::CAP_DONE);
    wire wr_go = taken && cfg_write;
    wire rd_go = taken && !cfg_write;
    wire a_pll = (cfg_addr == sncfg_pkg::REG_PLL);
    wire wr_ok = wr_go && !lock_all_reg;
    wire pll_ok = wr_ok && a_pll && !lock_pll_reg;
    wire rej = wr_go && (lock_all_reg || (a_pll && lock_pll_reg));
    wire w_cfg = wr_ok && (cfg_addr == sncfg_pkg::REG_SWCFG);
    wire w_node = wr_ok && (cfg_addr == sncfg_pkg::REG_NODE);
    wire w_swd = wr_ok && (cfg_addr == sncfg_pkg::REG_SWDIV);
    wire w_ref = wr_ok && (cfg_addr == sncfg_pkg::REG_REFDIV);
    wire w_dlo = wr_ok && (cfg_addr == sncfg_pkg::REG_DIRLO);
    wire w_dhi = wr_ok && (cfg_addr == sncfg_pkg::REG_DIRHI);
    wire [31:0] pll_seed = pll_rst({boot_strap_pin_b, boot_strap_pin_a});
    wire [31:0] pll_dflt = pll_rst(2'h0); // Until straps are in
    // -----------------------------------------------------------
    // Read data selection
    // -----------------------------------------------------------
    // identification word
    wire [31:0] w_ident = {CHIP_CODE, 6'h00, strap_reg, REVISION, VERSION};
    wire [31:0] w_desc = {8'h00, LINK_COUNT, CORE_COUNT, LINKS_PER_CORE};
    wire [31:0] w_cfgw = {lock_all_reg, 22'h000000, lock_pll_reg,
                          7'h00, hdr_reg};
    wire [31:0] w_pll = {6'h00, od_reg, 2'h0, fb_reg, 1'h0, in_reg};
    wire [31:0] rd_word =
        (cfg_addr == sncfg_pkg::REG_IDENT) ? w_ident :
        (cfg_addr == sncfg_pkg::REG_DESC) ? w_desc :
        (cfg_addr == sncfg_pkg::REG_SWCFG) ? w_cfgw :
        (cfg_addr == sncfg_pkg::REG_NODE) ? {16'h0000, node_reg} :
        a_pll ? w_pll :
        (cfg_addr == sncfg_pkg::REG_SWDIV) ? {16'h0000, swdiv_reg} :
        (cfg_addr == sncfg_pkg::REG_REFDIV) ? {16'h0000, refdiv_reg} :
        (cfg_addr == sncfg_pkg::REG_DIRLO) ? dirlo_reg :
        (cfg_addr == sncfg_pkg::REG_DIRHI) ? dirhi_reg :
        sncfg_pkg::ZERO_WORD;
    // -----------------------------------------------------------
    // Routing decode
    // -----------------------------------------------------------
    // compare from most significant bit
    wire [15:0] miss = route_dest ^ node_reg;
    wire [3:0] miss_idx = top_bit(miss);
    wire [63:0] dir_all = {dirhi_reg, dirlo_reg};
    wire [3:0] dir_pick = dir_all[{miss_idx, 2'b00} +: 4];
    // -----------------------------------------------------------
    // Strap capture
    // -----------------------------------------------------------
    // Straps are sampled on the first enabled edge after reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cap_reg <= sncfg_pkg::CAP_WAIT;
            strap_reg <= 2'h0;
        end else if (clk_en && cap_reg == sncfg_pkg::CAP_WAIT) begin
            cap_reg <= sncfg_pkg::CAP_DONE;
            strap_reg <= {boot_strap_pin_b, boot_strap_pin_a};
        end
    end
    // -----------------------------------------------------------
    // Switch configuration and node number
    // -----------------------------------------------------------
    // Locks may be written off again while the global lock is clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lock_all_reg <= 1'b0;
            lock_pll_reg <= 1'b0;
            hdr_reg <= 1'b0;
            node_reg <= sncfg_pkg::NODE_RST;
        end else if (clk_en) begin
            if (w_cfg) begin
                lock_all_reg <= cfg_wdata[sncfg_pkg::LOCK_ALL_BIT];
                lock_pll_reg <= cfg_wdata[sncfg_pkg::LOCK_PLL_BIT];
                hdr_reg <= cfg_wdata[sncfg_pkg::HDR_BIT];
            end
            if (w_node) begin
                node_reg <= cfg_wdata[sncfg_pkg::NODE_W-1:0];
            end
        end
    end
    // -----------------------------------------------------------
    // PLL settings
    // -----------------------------------------------------------
    // Reset value is only final once straps are in
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            od_reg <= pll_dflt[sncfg_pkg::OD_MSB:sncfg_pkg::OD_LSB];
            fb_reg <= pll_dflt[sncfg_pkg::FB_MSB:sncfg_pkg::FB_LSB];
            in_reg <= pll_dflt[sncfg_pkg::IN_MSB:sncfg_pkg::IN_LSB];
        end else if (clk_en && cap_reg == sncfg_pkg::CAP_WAIT) begin
            od_reg <= pll_seed[sncfg_pkg::OD_MSB:sncfg_pkg::OD_LSB];
            fb_reg <= pll_seed[sncfg_pkg::FB_MSB:sncfg_pkg::FB_LSB];
            in_reg <= pll_seed[sncfg_pkg::IN_MSB:sncfg_pkg::IN_LSB];
        end else if (clk_en && pll_ok) begin
            od_reg <= cfg_wdata[sncfg_pkg::OD_MSB:sncfg_pkg::OD_LSB];
            fb_reg <= cfg_wdata[sncfg_pkg::FB_MSB:sncfg_pkg::FB_LSB];
            in_reg <= cfg_wdata[sncfg_pkg::IN_MSB:sncfg_pkg::IN_LSB];
        end
    end
    // -----------------------------------------------------------
    // Dividers and direction tables
    // -----------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            swdiv_reg <= sncfg_pkg::SWDIV_RST;
            refdiv_reg <= sncfg_pkg::REFDIV_RST;
            dirlo_reg <= sncfg_pkg::DIR_RST;
            dirhi_reg <= sncfg_pkg::DIR_RST;
        end else if (clk_en) begin
            if (w_swd) begin
                swdiv_reg <= cfg_wdata[sncfg_pkg::DIV_W-1:0];
            end
            if (w_ref) begin
                refdiv_reg <= cfg_wdata[sncfg_pkg::DIV_W-1:0];
            end
            if (w_dlo) begin
                dirlo_reg <= cfg_wdata;
            end
            if (w_dhi) begin
                dirhi_reg <= cfg_wdata;
            end
        end
    end
    // -----------------------------------------------------------
    // Answer path
    // -----------------------------------------------------------
    // Answer lands on the edge after the request
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg_ack <= 1'b0;
            cfg_rejected <= 1'b0;
            cfg_rdata <= sncfg_pkg::ZERO_WORD;
            tile_reset <= 1'b0;
        end else if (clk_en) begin
            cfg_ack <= taken;
            cfg_rejected <= rej;
            cfg_rdata <= rd_go ? rd_word : sncfg_pkg::ZERO_WORD;
            tile_reset <= pll_ok;
        end
    end
    // -----------------------------------------------------------
    // Route lookup
    // -----------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            route_valid <= 1'b0;
            route_local <= 1'b0;
            route_dir <= 4'h0;
        end else if (clk_en) begin
            route_valid <= route_req;
            route_local <= route_req && (miss == 16'h0000);
            route_dir <= (route_req && miss != 16'h0000) ? dir_pick : 4'h0;
        end
    end
    // -----------------------------------------------------------
    // Clock tick dividers
    // -----------------------------------------------------------
    // Ticks stand for the derived clocks; one tick per period
    for (genvar g = 0; g < 2; g++) begin : g_div
        logic [15:0] cnt_reg;
        wire [15:0] lim = (g == 0) ? swdiv_reg : refdiv_reg;
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                cnt_reg <= 16'h0000;
                tick_reg[g] <= 1'b0;
            end else if (clk_en) begin
                if (cnt_reg >= lim) begin
                    cnt_reg <= 16'h0000;
                    tick_reg[g] <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    tick_reg[g] <= 1'b0;
                end
            end
        end
    end
    // -----------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------
    assign header_single_byte = hdr_reg;
    assign node_id = node_reg;
    assign pll_output_divider = od_reg;
    assign pll_feedback_mult = fb_reg;
    assign pll_input_div = in_reg;
    assign switch_clk_tick = tick_reg[0];
    assign ref_clk_tick = tick_reg[1];
    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_IDENT: assert property (rd_go && cfg_addr == 8'h00 |=>
        cfg_rdata == {CHIP_CODE, 6'h00, strap_reg, REVISION, VERSION})
        else $error("ident word wrong");
    AST_DESC: assert property (rd_go && cfg_addr == 8'h01 |=>
        cfg_rdata[23:0] == {LINK_COUNT, CORE_COUNT, LINKS_PER_CORE})
        else $error("description word wrong");
    AST_LOCK_ALL: assert property (wr_go && lock_all_reg |=>
        cfg_rejected && $stable(node_id) && $stable(lock_all_reg)
        && !tile_reset) else $error("locked write took effect");
    AST_LOCK_PLL: assert property (wr_go && a_pll && lock_pll_reg |=>
        $stable(pll_feedback_mult) && !tile_reset)
        else $error("PLL lock ignored");
    AST_HDR: assert property (w_cfg && clk_en |=>
        header_single_byte == $past(cfg_wdata[0]))
        else $error("header mode not stored");
    AST_NODE: assert property (w_node && clk_en |=>
        node_id == $past(cfg_wdata[15:0])) else $error("node not stored");
    AST_TILE: assert property (pll_ok |=> tile_reset)
        else $error("no tile reset on PLL write");
    AST_RSVD: assert property (rd_go && cfg_addr == 8'h05 |=>
        cfg_rdata[31:16] == 16'h0000) else $error("reserved not zero");
    AST_LOCAL: assert property (route_req && clk_en && miss == 16'h0
        |=> route_local && route_valid && route_dir == 4'h0)
        else $error("match not local");
    AST_DIR_HI: assert property (route_req && clk_en && miss[15]
        |=> route_dir == $past(dirhi_reg[31:28]) && !route_local)
        else $error("bit 15 direction wrong");
    AST_DIR_LO: assert property (clk_en && miss == 16'h0001
        && route_req |=> route_dir == $past(dirlo_reg[3:0]))
        else $error("bit 0 direction wrong");
    AST_ACK: assert property (taken |=> cfg_ack && cfg_rejected ==
        $past(cfg_write && (lock_all_reg || (a_pll && lock_pll_reg))))
        else $error("answer flag wrong");
    COV_LOCKED: cover property (wr_go && lock_all_reg ##1 cfg_rejected);
    COV_TILE: cover property (pll_ok ##1 tile_reset);
    COV_FWD: cover property (route_req && miss != 16'h0 ##1 route_valid);
    COV_LOCAL_HIT: cover property (route_req && miss == 16'h0);
endmodule : switch_node_config_regs

// *** sim/cfg_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Configuration host on the far side of the register port
// ----------------------------------------------------------------
module cfg_host_model (
    input wire logic sys_clk,
    output logic cfg_req,
    output logic cfg_write,
    output logic [7:0] cfg_addr,
    output logic [31:0] cfg_wdata,
    input wire logic cfg_ack,
    input wire logic cfg_rejected,
    input wire logic [31:0] cfg_rdata
);
    // Idle port at time zero
    initial begin
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_addr = 8'hff;
        cfg_wdata = 32'h0000_0000;
    end

    // One strobed access; released lines go inverted so stale values
    // can never pass for the real ones
    task automatic access(input logic wr, input logic [7:0] addr,
                          input logic [31:0] data,
                          output logic [31:0] rdata, output logic rej);
        int i;
        rdata = 32'hxxxx_xxxx;
        rej = 1'bx;
        @(posedge sys_clk);
        cfg_req <= 1'b1;
        cfg_write <= wr;
        cfg_addr <= addr;
        cfg_wdata <= data;
        @(posedge sys_clk);
        cfg_req <= 1'b0;
        cfg_write <= ~wr;
        cfg_addr <= ~addr;
        cfg_wdata <= ~data;
        // Bounded wait for the answer
        for (i = 0; i < 8; i++) begin
            #1;
            if (cfg_ack === 1'b1) begin
                rdata = cfg_rdata;
                rej = cfg_rejected;
                break;
            end
            @(posedge sys_clk);
        end
    endtask : access
endmodule : cfg_host_model

// *** sim/switch_node_config_regs_bench.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the switch node configuration bank
// ----------------------------------------------------------------
module switch_node_config_regs_bench;
    localparam logic [7:0] CHIP = 8'h3c; // Arbitrary value
    localparam logic [31:0] IDENT = {CHIP, 8'h03, 8'h02, 8'h07};
    localparam logic [31:0] DESC = 32'h0006_0203;
    logic sys_clk, rst_n, clk_en, pin_a, pin_b, route_req;
    logic [15:0] route_dest, node_id;
    logic cfg_req, cfg_write, cfg_ack, cfg_rejected;
    logic [7:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, pll_word;
    logic route_valid, route_local, header_single_byte, tile_reset;
    logic [3:0] route_dir;
    logic [2:0] pll_od;
    logic [12:0] pll_fb;
    logic [6:0] pll_in;
    logic sw_tick, ref_tick;
    logic [16:0] mask;
    int failures, checked, cycles, sw_n, ref_n, tr_n, t0, s0, r0, i;

    switch_node_config_regs #(.CHIP_CODE(CHIP), .REVISION(8'h02),
        .VERSION(8'h07), .LINK_COUNT(8'h06), .CORE_COUNT(8'h02),
        .LINKS_PER_CORE(8'h03)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .boot_strap_pin_a(pin_a), .boot_strap_pin_b(pin_b),
        .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rejected(cfg_rejected), .cfg_rdata(cfg_rdata),
        .route_req(route_req), .route_dest(route_dest),
        .route_valid(route_valid), .route_local(route_local),
        .route_dir(route_dir), .header_single_byte(header_single_byte),
        .node_id(node_id), .pll_output_divider(pll_od),
        .pll_feedback_mult(pll_fb), .pll_input_div(pll_in),
        .tile_reset(tile_reset), .switch_clk_tick(sw_tick),
        .ref_clk_tick(ref_tick));
    cfg_host_model i_host (.sys_clk(sys_clk), .cfg_req(cfg_req),
        .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rejected(cfg_rejected),
        .cfg_rdata(cfg_rdata));
    // PLL outputs laid out as the register word
    assign pll_word = {6'h00, pll_od, 2'h0, pll_fb, 1'b0, pll_in};

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Pulse counters and hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (sw_tick === 1'b1) sw_n++;
        if (ref_tick === 1'b1) ref_n++;
        if (tile_reset === 1'b1) tr_n++;
        if (cycles == 4000) begin
            failures++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic r);
        logic [31:0] q;
        logic j;
        i_host.access(1'b1, a, d, q, j);
        check({31'h0, j}, {31'h0, r});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        logic j;
        i_host.access(1'b0, a, 32'h0, q, j);
        check(q, e);
    endtask : rd
    task automatic route(input logic [15:0] d, input logic loc,
                         input logic [3:0] dir);
        int k;
        @(posedge sys_clk);
        route_req <= 1'b1;
        route_dest <= d;
        @(posedge sys_clk);
        route_req <= 1'b0;
        route_dest <= ~d;
        for (k = 0; k < 8; k++) begin
            #1;
            if (route_valid === 1'b1) break;
            @(posedge sys_clk);
        end
        check({26'h0, route_valid, route_local, route_dir},
              {26'h0, 1'b1, loc, dir});
    endtask : route
    // Counts ticks over n whole edges
    task automatic ticks(input int n, input int se, input int re);
        @(posedge sys_clk);
        #1;
        s0 = sw_n;
        r0 = ref_n;
        repeat (n) @(posedge sys_clk);
        #1;
        check(32'(sw_n - s0), 32'(se));
        check(32'(ref_n - r0), 32'(re));
    endtask : ticks
    task automatic complete_run;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        pin_a = 1'b1;
        pin_b = 1'b1;
        route_req = 1'b0;
        route_dest = 16'h0000;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check(pll_word, sncfg_pkg::PLL_RST_S3);
        check({15'h0, header_single_byte, node_id}, 32'h0);
        rd(sncfg_pkg::REG_IDENT, IDENT);
        rd(sncfg_pkg::REG_DESC, DESC);
        rd(sncfg_pkg::REG_SWCFG, 32'h0);
        rd(sncfg_pkg::REG_NODE, 32'h0);
        rd(sncfg_pkg::REG_PLL, sncfg_pkg::PLL_RST_S3);
        rd(sncfg_pkg::REG_SWDIV, 32'h0);
        rd(sncfg_pkg::REG_REFDIV, 32'h3);
        rd(sncfg_pkg::REG_DIRLO, 32'h0);
        rd(sncfg_pkg::REG_DIRHI, 32'h0);
        ticks(40, 40, 10);
        wr(sncfg_pkg::REG_IDENT, 32'hffff_ffff, 1'b0);
        rd(sncfg_pkg::REG_IDENT, IDENT);
        wr(8'h02, 32'hffff_ffff, 1'b0);
        rd(8'h02, 32'h0);
        wr(sncfg_pkg::REG_NODE, 32'hffff_ffff, 1'b0);
        rd(sncfg_pkg::REG_NODE, 32'h0000_ffff);
        wr(sncfg_pkg::REG_SWDIV, 32'hffff_0004, 1'b0);
        rd(sncfg_pkg::REG_SWDIV, 32'h4);
        wr(sncfg_pkg::REG_REFDIV, 32'hffff_0001, 1'b0);
        rd(sncfg_pkg::REG_REFDIV, 32'h1);
        ticks(20, 4, 10);
        t0 = tr_n;
        wr(sncfg_pkg::REG_PLL, 32'hffff_ffff, 1'b0);
        rd(sncfg_pkg::REG_PLL, 32'h039f_ff7f);
        check(32'(tr_n - t0), 32'h1);
        check(pll_word, 32'h039f_ff7f);
        // Same header mode on the only node in this system
        wr(sncfg_pkg::REG_SWCFG, 32'h7fff_feff, 1'b0);
        rd(sncfg_pkg::REG_SWCFG, 32'h1);
        check({31'h0, header_single_byte}, 32'h1);
        wr(sncfg_pkg::REG_DIRLO, 32'h7654_3210, 1'b0);
        wr(sncfg_pkg::REG_DIRHI, 32'hfedc_ba98, 1'b0);
        rd(sncfg_pkg::REG_DIRLO, 32'h7654_3210);
        rd(sncfg_pkg::REG_DIRHI, 32'hfedc_ba98);
        wr(sncfg_pkg::REG_NODE, 32'h0000_a5c3, 1'b0);
        check({16'h0, node_id}, 32'h0000_a5c3);
        route(16'ha5c3, 1'b1, 4'h0);
        // Flip bit i and all below: only bit i may choose
        for (i = 0; i < 16; i++) begin
            mask = (17'h1 << (i + 1)) - 17'h1;
            route(16'ha5c3 ^ mask[15:0], 1'b0, 4'(i));
        end
        // Lookups stand still while the clock enable is low
        @(posedge sys_clk);
        clk_en <= 1'b0;
        route_req <= 1'b1;
        route_dest <= 16'h0000;
        repeat (3) @(posedge sys_clk);
        #1;
        check({31'h0, route_valid}, 32'h0);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        route_req <= 1'b0;
        wr(sncfg_pkg::REG_SWCFG, 32'h0000_0101, 1'b0);
        t0 = tr_n;
        wr(sncfg_pkg::REG_PLL, 32'h0, 1'b1);
        rd(sncfg_pkg::REG_PLL, 32'h039f_ff7f);
        check(32'(tr_n - t0), 32'h0);
        wr(sncfg_pkg::REG_NODE, 32'h0000_1234, 1'b0);
        rd(sncfg_pkg::REG_NODE, 32'h0000_1234);
        wr(sncfg_pkg::REG_SWCFG, 32'h8000_0000, 1'b0);
        check({31'h0, header_single_byte}, 32'h0);
        wr(sncfg_pkg::REG_NODE, 32'h0, 1'b1);
        rd(sncfg_pkg::REG_NODE, 32'h0000_1234);
        wr(sncfg_pkg::REG_DIRLO, 32'h0, 1'b1);
        rd(sncfg_pkg::REG_DIRLO, 32'h7654_3210);
        wr(sncfg_pkg::REG_SWCFG, 32'h0, 1'b1);
        rd(sncfg_pkg::REG_SWCFG, 32'h8000_0000);
        // Second reset in mid-run clears the locks, new strap code 2
        @(posedge sys_clk);
        rst_n <= 1'b0;
        pin_a <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check(pll_word, sncfg_pkg::PLL_RST_S2);
        rd(sncfg_pkg::REG_SWCFG, 32'h0);
        rd(sncfg_pkg::REG_NODE, 32'h0);
        rd(sncfg_pkg::REG_IDENT, {CHIP, 8'h02, 8'h02, 8'h07});
        complete_run();
    end
endmodule : switch_node_config_regs_bench
